// *** logic/lcir_defs.vh ***
`ifndef LCIR_DEFS_VH
`define LCIR_DEFS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define LCIR_CONTRAST_ADDR   32'h00500844
`define LCIR_EN_SET_ADDR     32'h00500848
`define LCIR_EN_CLR_ADDR     32'h0050084C
`define LCIR_MASK_ADDR       32'h00500850
`define LCIR_ACTIVE_ADDR     32'h00500854
`define LCIR_PEND_CLR_ADDR   32'h00500858
`define LCIR_FORCE_ADDR      32'h00500860
`define LCIR_RAW_ADDR        32'h00500864

// ----------------------------------------------------------------------
// Interrupt field positions, shared by every interrupt register
// ----------------------------------------------------------------------
`define LCIR_EACH_ROW_BIT    0
`define LCIR_FINAL_ROW_BIT   1
`define LCIR_FRAME_DONE_BIT  2
`define LCIR_FIFO_EMPTY_BIT  4
`define LCIR_FIFO_OVERRUN_BIT 5
`define LCIR_MEM_FAULT_BIT   6
`define LCIR_SRC_VALID       7'h77

// ----------------------------------------------------------------------
// Contrast field and reset values
// ----------------------------------------------------------------------
`define LCIR_CONTRAST_MSB    7
`define LCIR_CONTRAST_LSB    0
`define LCIR_CONTRAST_RST    8'h00
`define LCIR_MASK_RST        7'h00
`define LCIR_PEND_RST        7'h00

// ----------------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------------
`define LCIR_HSIZE_WORD      3'h2
`define LCIR_HRESP_OKAY      1'h0

`endif

// *** logic/lcir_pend.v ***
`timescale 1ns/10ps
`default_nettype none
`include "lcir_defs.vh"

module lcir_pend #(
  parameter W = 7
) (
  input  wire         hclk,
  input  wire         hresetn,
  input  wire [W-1:0] set_vec,
  input  wire [W-1:0] clr_vec,
  output reg  [W-1:0] pend,
  output wire [W-1:0] next_pend
);

  // A source that fires in the same cycle as its clear stays pending,
  // so an event can never slip through a clear.
  assign next_pend = (pend & ~clr_vec) | set_vec;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= `LCIR_PEND_RST;
    end else begin
      pend <= next_pend;
    end
  end

endmodule
`default_nettype wire

// *** logic/lcir_regs.v ***
`timescale 1ns/10ps
`default_nettype none
`include "lcir_defs.vh"

// Function
// - Writable 8-bit contrast threshold in bits 7:0
// - All interrupt registers share one bit layout
// - Enable-set write of 1 sets mask bit
// - Enable-clear write of 1 clears mask bit
// - Mask register reads enabled sources as 1
// - Active register reads active sources as 1
// - Pending-clear write of 1 clears pending source
// - Force write of 1 sets pending source
// - FIFO underflow source on bit 4
// - FIFO overwrite source on bit 5
// - Memory error source on bit 6
// - Last-row source on bit 1, separate
// - Raw register shows pending regardless of mask
module lcir_regs #(
  parameter NSRC = 7
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        each_row_evt,
  input  wire        final_row_evt,
  input  wire        frame_done_evt,
  input  wire        fifo_empty_err_evt,
  input  wire        fifo_overrun_evt,
  input  wire        mem_fault_evt,
  output reg  [7:0]  contrast_threshold,
  output reg         irq
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function addr_hit;
    input [31:0] a;
    input [31:0] off;
    begin
      addr_hit = (a[31:2] == off[31:2]);
    end
  endfunction

  // Bit 3 and everything above bit 6 are reserved and never stored.
  function [NSRC-1:0] src_field;
    input [31:0] d;
    begin
      src_field = d[NSRC-1:0] & `LCIR_SRC_VALID;
    end
  endfunction

  function [31:0] widen;
    input [NSRC-1:0] v;
    begin
      widen = {{(32-NSRC){1'b0}}, v};
    end
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg  [NSRC-1:0] mask;
  reg             dp_valid;
  reg             dp_write;
  reg             dp_word;
  reg  [31:0]     dp_addr;

  wire [NSRC-1:0] pend;
  wire [NSRC-1:0] next_pend;
  reg  [NSRC-1:0] next_mask;
  reg  [NSRC-1:0] ev_vec;
  reg  [NSRC-1:0] set_vec;
  reg  [NSRC-1:0] clr_vec;
  reg  [NSRC-1:0] en_bits;
  reg  [NSRC-1:0] dis_bits;
  reg  [NSRC-1:0] icr_bits;
  reg  [NSRC-1:0] force_bits;
  reg  [NSRC-1:0] seen_pend;
  reg  [NSRC-1:0] seen_act;
  reg  [31:0]     next_hrdata;

  wire            take;
  wire            rd_take;
  wire            wr_act;
  wire [NSRC-1:0] wsrc;

  // --------------------------------------------------------------------
  // Bus address phase
  // --------------------------------------------------------------------
  // The slave never inserts wait states, so hready is the slave's own
  // hreadyout and every address phase is taken in one cycle.
  assign take    = hsel & htrans[1] & hready;
  assign rd_take = take & ~hwrite;
  assign wr_act  = dp_valid & dp_write & dp_word;
  assign wsrc    = src_field(hwdata);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_word  <= 1'b0;
      dp_addr  <= 32'h00000000;
    end else if (hready) begin
      dp_valid <= take;
      dp_write <= hwrite;
      dp_word  <= (hsize == `LCIR_HSIZE_WORD);
      dp_addr  <= haddr;
    end
  end

  // --------------------------------------------------------------------
  // Event sources
  // --------------------------------------------------------------------
  always @* begin
    ev_vec                          = {NSRC{1'b0}};
    ev_vec[`LCIR_EACH_ROW_BIT]      = each_row_evt;
    ev_vec[`LCIR_FINAL_ROW_BIT]     = final_row_evt;
    ev_vec[`LCIR_FRAME_DONE_BIT]    = frame_done_evt;
    ev_vec[`LCIR_FIFO_EMPTY_BIT]    = fifo_empty_err_evt;
    ev_vec[`LCIR_FIFO_OVERRUN_BIT]  = fifo_overrun_evt;
    ev_vec[`LCIR_MEM_FAULT_BIT]     = mem_fault_evt;
  end

  // --------------------------------------------------------------------
  // Write decode, taken in the data phase while hwdata stands
  // --------------------------------------------------------------------
  // Non-word writes are dropped: every register here is a whole word.
  always @* begin
    en_bits    = {NSRC{1'b0}};
    dis_bits   = {NSRC{1'b0}};
    icr_bits   = {NSRC{1'b0}};
    force_bits = {NSRC{1'b0}};
    if (wr_act && addr_hit(dp_addr, `LCIR_EN_SET_ADDR)) begin
      en_bits = wsrc;
    end
    if (wr_act && addr_hit(dp_addr, `LCIR_EN_CLR_ADDR)) begin
      dis_bits = wsrc;
    end
    if (wr_act && addr_hit(dp_addr, `LCIR_PEND_CLR_ADDR)) begin
      icr_bits = wsrc;
    end
    if (wr_act && addr_hit(dp_addr, `LCIR_FORCE_ADDR)) begin
      force_bits = wsrc;
    end
  end

  // --------------------------------------------------------------------
  // Mask
  // --------------------------------------------------------------------
  // Zeros written to either register leave the mask alone.
  always @* begin
    next_mask = (mask | en_bits) & ~dis_bits;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask <= `LCIR_MASK_RST;
    end else begin
      mask <= next_mask;
    end
  end

  // --------------------------------------------------------------------
  // Pending bits
  // --------------------------------------------------------------------
  // A read of the active register returns the state as it stands after
  // any write finishing in the same cycle, and then clears the bits it
  // reported, except those an event or force sets in that same cycle.
  // Bits that were pending but masked stay pending,
  // so they are not lost when software later enables them.
  always @* begin
    set_vec   = ev_vec | force_bits;
    seen_pend = (pend & ~icr_bits) | set_vec;
    seen_act  = seen_pend & next_mask;
    clr_vec   = icr_bits;
    if (rd_take && addr_hit(haddr, `LCIR_ACTIVE_ADDR)) begin
      clr_vec = icr_bits | seen_act;
    end
  end

  lcir_pend #(
    .W (NSRC)
  ) u_pend (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .set_vec   (set_vec),
    .clr_vec   (clr_vec),
    .pend      (pend),
    .next_pend (next_pend)
  );

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  // Read data is formed at the address-phase edge from the next state,
  // which keeps the bus at zero wait states yet never shows stale data
  // after a write still in its data phase, except on the contrast register.
  always @* begin
    next_hrdata = 32'h00000000;
    if (addr_hit(haddr, `LCIR_MASK_ADDR)) begin
      next_hrdata = widen(next_mask);
    end else if (addr_hit(haddr, `LCIR_ACTIVE_ADDR)) begin
      next_hrdata = widen(seen_act);
    end else if (addr_hit(haddr, `LCIR_RAW_ADDR)) begin
      next_hrdata = widen(seen_pend);
    end else if (addr_hit(haddr, `LCIR_CONTRAST_ADDR)) begin
      next_hrdata = {24'h000000, contrast_threshold};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= `LCIR_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= `LCIR_HRESP_OKAY;
      if (rd_take) begin
        hrdata <= next_hrdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // Contrast compare value
  // --------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      contrast_threshold <= `LCIR_CONTRAST_RST;
    end else if (wr_act && addr_hit(dp_addr, `LCIR_CONTRAST_ADDR)) begin
      contrast_threshold <=
        hwdata[`LCIR_CONTRAST_MSB:`LCIR_CONTRAST_LSB];
    end
  end

  // --------------------------------------------------------------------
  // Interrupt output
  // --------------------------------------------------------------------
  // Registered from the next state, so irq follows the status register
  // exactly one edge after any cause.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_pend & next_mask);
    end
  end

endmodule
`default_nettype wire

// *** sim/lcir_regs_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "lcir_defs.vh"
module lcir_regs_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [7:0]  contrast_threshold,
  input wire logic        irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire ap     = hsel && htrans[1] && hready;
  wire rd_ap  = ap && !hwrite;
  wire rd_act = rd_ap && haddr == `LCIR_ACTIVE_ADDR;
  reg  wr_c;
  reg  wr_dp;
  reg  rd_un;
  reg  rd_irq;
  // Flags mark the data phase that follows an accepted address phase.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_c   <= 1'b0;
      wr_dp  <= 1'b0;
      rd_un  <= 1'b0;
      rd_irq <= 1'b0;
    end else begin
      wr_c   <= ap && hwrite && hsize == `LCIR_HSIZE_WORD &&
                haddr == `LCIR_CONTRAST_ADDR;
      wr_dp  <= ap && hwrite;
      rd_un  <= rd_ap && haddr[31:12] != 20'h00500;
      rd_irq <= rd_ap && (haddr == `LCIR_MASK_ADDR ||
                haddr == `LCIR_ACTIVE_ADDR || haddr == `LCIR_RAW_ADDR);
    end
  end
  hready_one_a: assert property (hreadyout == 1'b1)
    else $error("hreadyout not high");
  okay_resp_a: assert property (hresp == `LCIR_HRESP_OKAY)
    else $error("hresp not okay");
  contrast_load_a: assert property (
    wr_c |=> contrast_threshold == $past(hwdata[7:0]))
    else $error("contrast not loaded");
  contrast_hold_a: assert property (
    !wr_c |=> $stable(contrast_threshold))
    else $error("contrast changed without write");
  unmapped_zero_a: assert property (rd_un |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  reserved_zero_a: assert property (
    rd_irq |-> hrdata[31:7] == 25'h0 && hrdata[3] == 1'b0)
    else $error("reserved bits not zero");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(wr_dp) || $past(rd_act) || $past(rd_act, 2))
    else $error("irq fell without software action");
  rdata_hold_a: assert property (!rd_ap |=> $stable(hrdata))
    else $error("hrdata changed without read");
  cover property (wr_c);
  cover property (rd_irq && hrdata != 32'h0);
  cover property ($fell(irq));
endmodule
bind lcir_regs lcir_regs_chk chk_u (.*);
`default_nettype wire

// *** sim/lcd_irq_and_contrast_regs_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "lcir_defs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("wrong value %s exp %h got %h", n, e, g); end end
module lcd_irq_and_contrast_regs_tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [6:0]  evt = 7'h00;
  logic        rdp = 1'b0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         irq;
  wire  [7:0]  ct;
  logic [31:0] expq[$];
  logic [31:0] ex;
  logic [31:0] c;
  logic [6:0]  m;
  logic [6:0]  f;
  logic [6:0]  k;
  int          bl[6] = '{0, 1, 2, 4, 5, 6};
  int          error_cnt = 0;
  int          check_count = 0;
  always #2 hclk = ~hclk;
  lcir_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .each_row_evt(evt[0]),
    .final_row_evt(evt[1]), .frame_done_evt(evt[2]),
    .fifo_empty_err_evt(evt[4]), .fifo_overrun_evt(evt[5]),
    .mem_fault_evt(evt[6]), .contrast_threshold(ct), .irq(irq));
  // Read data is judged at the edge that closes its data phase.
  always @(posedge hclk) begin
    if (rdp) begin
      ex = expq.pop_front();
      `CHK("hrdata", ex, hrdata)
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task wready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        error_cnt++;
        summarize;
      end
      @(posedge hclk);
    end
  endtask
  // For a read, d is the expected word.
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wready;
    if (!w)
      expq.push_back(d);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdp <= !w;
    wready;
    rdp <= 1'b0;
  endtask
  task ck_irq(input logic e);
    @(negedge hclk);
    `CHK("irq", e, irq)
  endtask
  initial begin
    void'($urandom(94845));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, `LCIR_MASK_ADDR, 32'h0);
    bus(0, `LCIR_RAW_ADDR, 32'h0);
    bus(0, 32'h00500900, 32'h0);
    bus(0, 32'h00601000, 32'h0);
    c = $urandom;
    bus(1, `LCIR_CONTRAST_ADDR, c);
    bus(0, `LCIR_CONTRAST_ADDR, {24'h0, c[7:0]});
    ck_irq(1'b0);
    `CHK("contrast", c[7:0], ct)
    $display("test reset and contrast done");
    m = $urandom & 7'h77;
    k = $urandom;
    bus(1, `LCIR_EN_SET_ADDR, {25'h0, m});
    bus(1, `LCIR_EN_SET_ADDR, 32'h0);
    bus(1, `LCIR_MASK_ADDR, 32'hFFFFFFFF);
    bus(0, `LCIR_MASK_ADDR, {25'h0, m});
    bus(1, `LCIR_EN_CLR_ADDR, {25'h0, k});
    m = m & ~k;
    bus(0, `LCIR_MASK_ADDR, {25'h0, m});
    f = $urandom & 7'h77;
    bus(1, `LCIR_FORCE_ADDR, {25'h0, f});
    ck_irq(|(f & m));
    bus(0, `LCIR_RAW_ADDR, {25'h0, f});
    bus(0, `LCIR_ACTIVE_ADDR, {25'h0, f & m});
    bus(0, `LCIR_ACTIVE_ADDR, 32'h0);
    bus(0, `LCIR_RAW_ADDR, {25'h0, f & ~m});
    bus(1, `LCIR_PEND_CLR_ADDR, {25'h0, f});
    bus(0, `LCIR_RAW_ADDR, 32'h0);
    $display("test mask and force done");
    bus(1, `LCIR_EN_SET_ADDR, 32'h77);
    foreach (bl[i]) begin
      @(posedge hclk);
      evt <= 7'h01 << bl[i];
      @(posedge hclk);
      evt <= 7'h00;
      ck_irq(1'b1);
      bus(0, `LCIR_RAW_ADDR, 32'h1 << bl[i]);
      bus(0, `LCIR_ACTIVE_ADDR, 32'h1 << bl[i]);
      ck_irq(1'b0);
    end
    $display("test events done");
    bus(1, `LCIR_EN_CLR_ADDR, 32'hFFFFFFFF);
    bus(1, `LCIR_FORCE_ADDR, 32'h7F);
    ck_irq(1'b0);
    bus(0, `LCIR_ACTIVE_ADDR, 32'h0);
    bus(0, `LCIR_RAW_ADDR, 32'h77);
    $display("test disable done");
    summarize;
  end
endmodule
`default_nettype wire
